// File: verilog/adcsm_regs.vh
`ifndef ADCSM_REGS_VH
`define ADCSM_REGS_VH

// ----------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------
`define ADCSM_SAMPLE_OFS   4'h0
`define ADCSM_STATUS_OFS   4'h4
`define ADCSM_IRQ_STAT_OFS 4'h8
`define ADCSM_IRQ_MASK_OFS 4'hC

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ADCSM_ST_STATE_LSB 0
`define ADCSM_ST_MODE_BIT  2
`define ADCSM_ST_BUSY_BIT  3
`define ADCSM_ST_PD_BIT    4
`define ADCSM_ST_CODE_LSB  16
`define ADCSM_IRQ_CONV_BIT 0
`define ADCSM_IRQ_READ_BIT 1
`define ADCSM_IRQ_W        2

// ----------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------
`define ADCSM_SAMPLE_RST   18'h0_0000
`define ADCSM_CODE_MAX     16'hFFFF
`define ADCSM_CODE_MIN     16'h0000
`define ADCSM_RESP_OKAY    2'h0
`define ADCSM_RESP_SLVERR  2'h2

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define ADCSM_CLK_PERIOD_NS 10
`define ADCSM_CONV_T_NS     710
`define ADCSM_CONV_CYC      ((`ADCSM_CONV_T_NS) / (`ADCSM_CLK_PERIOD_NS))
`define ADCSM_BITS_PLAIN    5'd16
`define ADCSM_BITS_BUSY     5'd17

`endif

// File: verilog/adcsm_top.v
`timescale 1ns/10ps
`include "adcsm_regs.vh"

module adcsm_top (
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // AXI4-Lite write address
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Converter pins
  input  wire        convert_start,
  input  wire        serial_in_select,
  input  wire        sck,
  output reg         serial_result_out,
  output reg         serial_result_oe,
  // Status
  output reg         power_down,
  output reg         irq
);

  // ----------------------------------------------------------------
  // Constants
  // ----------------------------------------------------------------
  localparam [1:0] ST_ACQ  = 2'd0;
  localparam [1:0] ST_CONV = 2'd1;
  localparam [1:0] ST_READ = 2'd2;
  localparam [31:0] CONV_CYC_W = `ADCSM_CONV_CYC;
  localparam [7:0]  CONV_CYC   = CONV_CYC_W[7:0];

  function [15:0] saturate;
    input [17:0] s;
    begin
      if (s[17])
        saturate = `ADCSM_CODE_MIN;
      else if (s[16])
        saturate = `ADCSM_CODE_MAX;
      else
        saturate = s[15:0];
    end
  endfunction

  function [31:0] merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  strb;
    integer i;
    begin
      merge = old_v;
      for (i = 0; i < 4; i = i + 1)
        if (strb[i])
          merge[i*8 +: 8] = new_v[i*8 +: 8];
    end
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  reg [1:0] cnv_sy_q;
  reg [1:0] sdi_sy_q;
  reg [1:0] sck_sy_q;
  reg       cnv_prev_q;
  reg       sdi_prev_q;
  reg       sck_prev_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      cnv_sy_q   <= 2'b00;
      sdi_sy_q   <= 2'b00;
      sck_sy_q   <= 2'b00;
      cnv_prev_q <= 1'b0;
      sdi_prev_q <= 1'b0;
      sck_prev_q <= 1'b0;
    end else begin
      cnv_sy_q   <= {cnv_sy_q[0], convert_start};
      sdi_sy_q   <= {sdi_sy_q[0], serial_in_select};
      sck_sy_q   <= {sck_sy_q[0], sck};
      cnv_prev_q <= cnv_sy_q[1];
      sdi_prev_q <= sdi_sy_q[1];
      sck_prev_q <= sck_sy_q[1];
    end
  end

  wire cnv_s    = cnv_sy_q[1];
  wire sdi_s    = sdi_sy_q[1];
  wire sck_s    = sck_sy_q[1];
  wire cnv_rise = cnv_s & ~cnv_prev_q;
  wire sck_fall = ~sck_s & sck_prev_q;
  // Select active when either framing pin is low
  wire sel      = ~(cnv_s & sdi_s);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg [17:0]              sample_q;
  reg [`ADCSM_IRQ_W-1:0]  irq_stat_q;
  reg [`ADCSM_IRQ_W-1:0]  irq_mask_q;
  reg [1:0]               state_q;
  reg                     mode_sel_q;
  reg                     busy_en_q;
  reg [15:0]              code_q;
  reg [16:0]              shift_q;
  reg [4:0]               bit_cnt_q;
  reg [7:0]               conv_cnt_q;
  reg                     was_sel_q;
  reg [3:0]               awaddr_q;
  reg                     aw_full_q;
  reg [31:0]              wdata_q;
  reg [3:0]               wstrb_q;
  reg                     w_full_q;

  wire do_write  = aw_full_q & w_full_q & ~s_axi_bvalid;
  wire conv_done = (state_q == ST_CONV) && (conv_cnt_q == CONV_CYC - 8'd1);
  wire busy_end  = mode_sel_q ? (~cnv_s | ~sdi_s) : busy_en_q;
  wire [4:0] nbits = busy_en_q ? `ADCSM_BITS_BUSY : `ADCSM_BITS_PLAIN;
  wire read_end  = (state_q == ST_READ) && mode_sel_q &&
                   ((was_sel_q & ~sel) ||
                    (sel & sck_fall & (bit_cnt_q == nbits - 5'd1)));
  wire [`ADCSM_IRQ_W-1:0] ev = {read_end, conv_done};
  wire [31:0] w_merged = merge({14'h0000, sample_q}, wdata_q, wstrb_q);
  wire [`ADCSM_IRQ_W-1:0] w1c =
    (do_write && awaddr_q == `ADCSM_IRQ_STAT_OFS) ? wdata_q[`ADCSM_IRQ_W-1:0] :
    {`ADCSM_IRQ_W{1'b0}};
  wire [31:0] status_w;
  assign status_w = {code_q, 11'h000, power_down, busy_en_q, mode_sel_q, state_q};

  // ----------------------------------------------------------------
  // Conversion and readout engine
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_q           <= ST_ACQ;
      mode_sel_q        <= 1'b1;
      busy_en_q         <= 1'b0;
      code_q            <= 16'h0000;
      shift_q           <= 17'h0_0000;
      bit_cnt_q         <= 5'd0;
      conv_cnt_q        <= 8'd0;
      was_sel_q         <= 1'b0;
      serial_result_out <= 1'b0;
      serial_result_oe  <= 1'b0;
      power_down        <= 1'b1;
    end else if (cnv_rise && state_q != ST_CONV) begin
      state_q          <= ST_CONV;
      mode_sel_q       <= sdi_prev_q;
      busy_en_q        <= sck_s;
      code_q           <= saturate(sample_q);
      conv_cnt_q       <= 8'd0;
      serial_result_oe <= 1'b0;
      power_down       <= 1'b0;
    end else begin
      case (state_q)
        ST_CONV: begin
          // Internal count only; sck is ignored here
          conv_cnt_q <= conv_cnt_q + 8'd1;
          if (conv_done) begin
            state_q    <= ST_READ;
            power_down <= 1'b1;
            bit_cnt_q  <= 5'd0;
            was_sel_q  <= 1'b0;
            if (mode_sel_q)
              busy_en_q <= busy_end;
            // Busy start bit is a leading zero ahead of the code
            if (busy_end)
              shift_q <= {1'b0, code_q};
            else
              shift_q <= {code_q, 1'b0};
          end
        end
        ST_READ: begin
          was_sel_q <= sel;
          if (read_end) begin
            state_q          <= ST_ACQ;
            serial_result_oe <= 1'b0;
          end else begin
            serial_result_oe  <= sel;
            serial_result_out <= shift_q[16];
            if (sel && sck_fall) begin
              // Without a start bit the low slot stays empty, so upstream
              // data follows the 16th result bit with no gap
              if (busy_en_q)
                shift_q <= {shift_q[15:0], sdi_s};
              else
                shift_q <= {shift_q[15:1], sdi_s, 1'b0};
              bit_cnt_q <= bit_cnt_q + 5'd1;
              serial_result_out <= shift_q[15];
            end
          end
        end
        default: begin
          state_q          <= ST_ACQ;
          serial_result_oe <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write side
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `ADCSM_RESP_OKAY;
      aw_full_q     <= 1'b0;
      w_full_q      <= 1'b0;
      awaddr_q      <= 4'h0;
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
      sample_q      <= `ADCSM_SAMPLE_RST;
      irq_mask_q    <= {`ADCSM_IRQ_W{1'b0}};
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_q      <= s_axi_awaddr;
        aw_full_q     <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
        w_full_q     <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_full_q    <= 1'b0;
        w_full_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `ADCSM_RESP_OKAY;
        case (awaddr_q)
          `ADCSM_SAMPLE_OFS:   sample_q <= w_merged[17:0];
          `ADCSM_IRQ_MASK_OFS: begin
            if (wstrb_q[0])
              irq_mask_q <= wdata_q[`ADCSM_IRQ_W-1:0];
          end
          `ADCSM_STATUS_OFS, `ADCSM_IRQ_STAT_OFS: s_axi_bresp <= `ADCSM_RESP_OKAY;
          default:             s_axi_bresp <= `ADCSM_RESP_SLVERR;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_q <= {`ADCSM_IRQ_W{1'b0}};
      irq        <= 1'b0;
    end else begin
      // Set beats a same-cycle clear
      irq_stat_q <= (irq_stat_q & ~(w1c & {`ADCSM_IRQ_W{wstrb_q[0]}})) | ev;
      irq        <= |(irq_stat_q & irq_mask_q);
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read side
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `ADCSM_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= `ADCSM_RESP_OKAY;
      case (s_axi_araddr)
        `ADCSM_SAMPLE_OFS:   s_axi_rdata <= {14'h0000, sample_q};
        `ADCSM_STATUS_OFS:   s_axi_rdata <= status_w;
        `ADCSM_IRQ_STAT_OFS: s_axi_rdata <= {30'h0000_0000, irq_stat_q};
        `ADCSM_IRQ_MASK_OFS: s_axi_rdata <= {30'h0000_0000, irq_mask_q};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `ADCSM_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule // adcsm_top

// File: tb/adcsm_checker_properties.sv
`timescale 1ns/10ps
module adcsm_checker (
  // Clock and reset
  input wire        aclk,
  input wire        aresetn,
  // Bus handshakes
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [31:0] s_axi_rdata,
  // Converter pins
  input wire        convert_start,
  input wire        serial_in_select,
  input wire        serial_result_oe,
  input wire        power_down
);
  logic [7:0] low_cnt_q;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ------
  // Conversion length, counted in helper logic
  // ------
  always @(posedge aclk) begin
    if (!aresetn || power_down)
      low_cnt_q <= 8'h00;
    else
      low_cnt_q <= low_cnt_q + 8'h01;
  end
  chk_b_held: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  chk_b_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write response late");
  chk_r_held: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  chk_r_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid && !s_axi_arready) else $error("read answer late");
  chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while answering");
  chk_conv_len: assert property (
    $rose(power_down) |-> low_cnt_q inside {[8'd70:8'd72]}) else $error("conversion length");
  chk_conv_cause: assert property (
    $fell(power_down) |-> $past(convert_start, 2)) else $error("conversion without start");
  chk_quiet_conv: assert property (
    !power_down [*6] |-> !serial_result_oe) else $error("output driven in conversion");
  chk_desel_off: assert property (
    (convert_start && serial_in_select) [*6] |-> !serial_result_oe)
    else $error("output driven while deselected");
  cov_conv: cover property ($rose(power_down));
  cov_frame_end: cover property ($fell(serial_result_oe));
  cov_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule // adcsm_checker
bind adcsm_top adcsm_checker adcsm_checker_inst (.*);

// File: tb/adcsm_host.sv
`timescale 1ns/10ps
module adcsm_host (
  // Clock
  input  wire  aclk,
  // Result line
  input  wire  res_data,
  input  wire  res_oe,
  // Control lines
  output logic convert_start,
  output logic serial_in_select,
  output logic sck
);
  logic last_q;
  wire  line;
  // No pull on the line: released, it shows the inverse of its last level
  assign line = res_oe ? res_data : ~last_q;
  always @(posedge aclk) begin
    if (res_oe)
      last_q <= res_data;
  end
  initial begin
    convert_start    = 1'b0;
    serial_in_select = 1'b1;
    sck              = 1'b0;
    last_q           = 1'b0;
  end
  // ------
  // Conversion start, then wait out the longest conversion
  // ------
  task automatic convert(input logic sel_v, input logic sck_v, input logic drop, input logic tie);
    @(posedge aclk);
    convert_start    <= 1'b0;
    serial_in_select <= sel_v;
    sck              <= sck_v;
    repeat (4) @(posedge aclk);
    convert_start <= 1'b1;
    if (tie)
      serial_in_select <= 1'b1;
    repeat (4) @(posedge aclk);
    sck <= 1'b0;
    if (drop)
      serial_in_select <= 1'b0;
    repeat (90) @(posedge aclk);
  endtask
  // Link clock runs only inside a frame, free of the block clock phase
  task automatic read_frame(input int n, output logic [19:0] bits);
    bits = 20'h0_0000;
    for (int i = 0; i < n; i++) begin
      #62.5;
      bits = {bits[18:0], line};
      sck <= 1'b1;
      #62.5;
      sck <= 1'b0;
    end
    #62.5;
    @(posedge aclk);
  endtask
endmodule // adcsm_host

// File: tb/testbench.sv
`timescale 1ns/10ps
`include "adcsm_regs.vh"
module testbench;
  typedef struct packed {logic [17:0] samp; logic three; logic [15:0] code;} adcsm_row_t;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [3:0]  awaddr, araddr, wstrb;
  logic [31:0] wdata, rd;
  logic [1:0]  rsp;
  logic [19:0] bits;
  wire         awready, wready, bvalid, arready, rvalid, dout, oe, pd, irq;
  wire         start_pin, sel_pin, sck;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  int          failures, checks_done, cyc;
  logic [3:0]  rst_a [3] = '{`ADCSM_SAMPLE_OFS, `ADCSM_IRQ_STAT_OFS, `ADCSM_IRQ_MASK_OFS};
  // Sample word, three-wire select, expected code
  adcsm_row_t  rows [5] = '{'{18'h0_1234, 1'b1, 16'h1234}, '{18'h3_FFFF, 1'b0, 16'h0000},
    '{18'h1_0000, 1'b1, 16'hFFFF}, '{18'h0_FFFF, 1'b0, 16'hFFFF}, '{18'h0_8001, 1'b1, 16'h8001}};
  adcsm_top adcsm_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .convert_start(start_pin), .serial_in_select(sel_pin), .sck(sck),
    .serial_result_out(dout), .serial_result_oe(oe), .power_down(pd), .irq(irq));
  adcsm_host adcsm_host_inst (.aclk(aclk), .res_data(dout), .res_oe(oe),
    .convert_start(start_pin), .serial_in_select(sel_pin), .sck(sck));
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // A hung handshake ends the run here
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      stop_test();
    end
  end
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b1;
    do @(posedge aclk); while (!bvalid);
    rsp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rdreg(input logic [3:0] a);
    araddr  <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    // One edge with rready low exercises the held-answer check
    @(posedge aclk);
    rready <= 1'b1;
    do @(posedge aclk); while (!rvalid);
    rd  = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask
  task automatic st_chk(input logic mode, input logic busy, input logic [15:0] code);
    rdreg(`ADCSM_STATUS_OFS);
    check({rd[31:16], rd[4:2]}, {code, 1'b1, busy, mode});
  endtask
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata} = 40'h00_0000_0000;
    wstrb = 4'hF;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check(pd, 1);
    check(oe, 0);
    check(irq, 0);
    foreach (rst_a[i]) begin
      rdreg(rst_a[i]);
      check(rd, 0);
    end
    $display("test reset done");
    foreach (rows[i]) begin
      wr(`ADCSM_SAMPLE_OFS, {14'h0, rows[i].samp});
      adcsm_host_inst.convert(1'b1, 1'b0, 1'b0, 1'b0);
      st_chk(1'b1, 1'b0, rows[i].code);
      if (rows[i].three) adcsm_host_inst.convert_start <= 1'b0;
      else adcsm_host_inst.serial_in_select <= 1'b0;
      @(posedge aclk);
      adcsm_host_inst.read_frame(16, bits);
      check(bits[15:0], rows[i].code);
      repeat (8) @(posedge aclk);
      check(oe, 0);
    end
    $display("test table done");
    rdreg(`ADCSM_IRQ_STAT_OFS);
    check(rd, 3);
    check(irq, 0);
    wr(`ADCSM_IRQ_MASK_OFS, 2);
    repeat (3) @(posedge aclk);
    check(irq, 1);
    wr(`ADCSM_IRQ_STAT_OFS, 2);
    rdreg(`ADCSM_IRQ_STAT_OFS);
    check(rd, 1);
    check(irq, 0);
    wr(4'h6, 32'hFFFF_FFFF);
    check(rsp, `ADCSM_RESP_SLVERR);
    rdreg(4'h6);
    check({rd[29:0], rsp}, `ADCSM_RESP_SLVERR);
    wr(`ADCSM_STATUS_OFS, 0);
    check(rsp, `ADCSM_RESP_OKAY);
    $display("test registers done");
    adcsm_host_inst.convert(1'b1, 1'b0, 1'b1, 1'b0);
    st_chk(1'b1, 1'b1, 16'h8001);
    adcsm_host_inst.read_frame(17, bits);
    check(bits[16:0], {1'b0, 16'h8001});
    repeat (8) @(posedge aclk);
    check(oe, 0);
    adcsm_host_inst.convert(1'b0, 1'b0, 1'b0, 1'b1);
    st_chk(1'b0, 1'b0, 16'h8001);
    adcsm_host_inst.convert(1'b0, 1'b1, 1'b0, 1'b0);
    st_chk(1'b0, 1'b1, 16'h8001);
    adcsm_host_inst.convert(1'b0, 1'b0, 1'b0, 1'b0);
    st_chk(1'b0, 1'b0, 16'h8001);
    adcsm_host_inst.convert_start <= 1'b0;
    adcsm_host_inst.serial_in_select <= 1'b1;
    @(posedge aclk);
    adcsm_host_inst.read_frame(20, bits);
    check(bits, {16'h8001, 4'hF});
    $display("test modes done");
    stop_test();
  end
endmodule // testbench
